/* design/iod_pkg.sv */
// Package of address map and timing constants for the I/O port decoder
package iod_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Group base addresses, in port address units
  localparam logic [7:0] DISP_BASE = 8'h00;
  localparam logic [7:0] FLOP_BASE = 8'h04;
  localparam logic [7:0] SER_BASE = 8'h08;
  localparam logic [7:0] TMR_BASE = 8'h0C;
  localparam logic [7:0] PAR_BASE = 8'h10;
  localparam logic [7:0] SW_BASE = 8'h14;
  localparam logic [7:0] DMA_BASE = 8'hF0;

  // Group sizes expressed as the number of low address bits passed through
  localparam int unsigned SMALL_LOW_W = 2;
  localparam int unsigned DMA_LOW_W = 4;

  // Drive control bit positions in the switch port write data
  localparam int unsigned MOTOR_BIT = 0;
  localparam int unsigned LARGE_BIT = 1;

  // Reset values of the drive control latches
  localparam logic MOTOR_RST = 1'b0;
  localparam logic LARGE_RST = 1'b0;

  // Reset value of the switch synchroniser and read data register
  localparam logic [7:0] SW_RST = 8'h00;

  // Memory cycle stretch, in wait cycles
  localparam logic [1:0] MEM_WAITS = 2'h1;

  // Index of each chip select in the one-hot select vector
  localparam int unsigned SEL_DISP = 0;
  localparam int unsigned SEL_FLOP = 1;
  localparam int unsigned SEL_SER = 2;
  localparam int unsigned SEL_TMR = 3;
  localparam int unsigned SEL_PAR = 4;
  localparam int unsigned SEL_SW = 5;
  localparam int unsigned SEL_DMA = 6;
  localparam int unsigned SEL_N = 7;

  // Memory wait state machine
  typedef enum logic [1:0] {IOD_IDLE, IOD_WAIT, IOD_DONE} iod_wait_t;

endpackage

/* design/iod_group_match.sv */
// Compares the upper address bits against one port group base
module iod_group_match
  import iod_pkg::*;
#(
  parameter int unsigned LOW_W = 2,
  parameter logic [7:0] BASE = 8'h00
)
(
  input wire logic [7:0] addr,
  input wire logic enable,
  output logic hit
);

  // Upper bits decide the group, low bits stay with the device
  assign hit = enable && (addr[7:LOW_W] == BASE[7:LOW_W]);

endmodule // iod_group_match

/* design/iod_decoder.sv */
// I/O port address decoder with switch port and memory wait stretch
// Summary of operation
// - Every peripheral owns four consecutive ports, the DMA controller sixteen.
// - Ports 00 to 03 select the display controller, 00 parameter and 01 command.
// - Ports 04 to 07 select the floppy controller, 04 main status and 05 data.
// - Ports 08 to 0B select the dual serial controller, data A, data B, control A, control B.
// - Ports 0C to 0F select timer channels 0 to 3 in order.
// - Ports 10 to 13 select the parallel port controller in its four register order.
// - A read of the switch group at 14 returns the eight switch bits on the data bus.
// - A write to the switch group latches bit 0 as motor enable and bit 1 as large drive select.
// - Every memory cycle is stretched by one wait state.
// - Ports F0 to FF select the DMA controller with all sixteen registers reachable.
module iod_decoder
  import iod_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic iorq_n,
  input wire logic mreq_n,
  input wire logic m1_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] switch_pins,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic display_select,
  output logic floppy_select,
  output logic serial_controller_select,
  output logic timer_controller_select,
  output logic parallel_port_select,
  output logic dma_select,
  output logic [3:0] reg_index,
  output logic motor_enable,
  output logic large_drive_select,
  output logic wait_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle qualification and group decode

  logic io_cycle;
  logic [SEL_N-1:0] sel;
  logic [7:0] sw_meta_q;
  logic [7:0] sw_sync_q;
  logic wr_n_q;
  logic motor_q;
  logic large_q;
  iod_wait_t wst_q;
  iod_wait_t wst_d;
  logic mem_active;

  // I/O request without M1 is a real port cycle
  assign io_cycle = !iorq_n && m1_n;

  iod_group_match #(.LOW_W(SMALL_LOW_W), .BASE(DISP_BASE)) u_disp
  (
    .addr(addr),
    .enable(io_cycle),
    .hit(sel[SEL_DISP])
  );

  iod_group_match #(.LOW_W(SMALL_LOW_W), .BASE(FLOP_BASE)) u_flop
  (
    .addr(addr),
    .enable(io_cycle),
    .hit(sel[SEL_FLOP])
  );

  iod_group_match #(.LOW_W(SMALL_LOW_W), .BASE(SER_BASE)) u_ser
  (
    .addr(addr),
    .enable(io_cycle),
    .hit(sel[SEL_SER])
  );

  iod_group_match #(.LOW_W(SMALL_LOW_W), .BASE(TMR_BASE)) u_tmr
  (
    .addr(addr),
    .enable(io_cycle),
    .hit(sel[SEL_TMR])
  );

  iod_group_match #(.LOW_W(SMALL_LOW_W), .BASE(PAR_BASE)) u_par
  (
    .addr(addr),
    .enable(io_cycle),
    .hit(sel[SEL_PAR])
  );

  iod_group_match #(.LOW_W(SMALL_LOW_W), .BASE(SW_BASE)) u_sw
  (
    .addr(addr),
    .enable(io_cycle),
    .hit(sel[SEL_SW])
  );

  iod_group_match #(.LOW_W(DMA_LOW_W), .BASE(DMA_BASE)) u_dma
  (
    .addr(addr),
    .enable(io_cycle),
    .hit(sel[SEL_DMA])
  );

  // Chip selects out, one per group except the switch group, whose select stays internal
  assign display_select = sel[SEL_DISP];
  assign floppy_select = sel[SEL_FLOP];
  assign serial_controller_select = sel[SEL_SER];
  assign timer_controller_select = sel[SEL_TMR];
  assign parallel_port_select = sel[SEL_PAR];
  assign dma_select = sel[SEL_DMA];

  // Low bits pass through for register choice inside the device
  assign reg_index = addr[DMA_LOW_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Switch port read path

  // Two-stage synchroniser on the switch pins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sw_meta_q <= SW_RST;
      sw_sync_q <= SW_RST;
    end
    else
    begin
      sw_meta_q <= switch_pins;
      sw_sync_q <= sw_meta_q;
    end
  end

  // Registered read data, driven while the switch group is read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      data_out <= SW_RST;
    else
      data_out <= sw_sync_q;
  end

  // Bus drive enable, low while driving
  assign data_oe_n = !(sel[SEL_SW] && !rd_n);

  ////////////////////////////////////////////////////////////////////////////
  // Drive control latches

  // Write strobe delay for edge detection
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wr_n_q <= 1'b1;
    else
      wr_n_q <= wr_n;
  end

  // Latch on the first cycle of a switch group write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      motor_q <= MOTOR_RST;
      large_q <= LARGE_RST;
    end
    else if (sel[SEL_SW] && !wr_n && wr_n_q)
    begin
      motor_q <= data_in[MOTOR_BIT];
      large_q <= data_in[LARGE_BIT];
    end
  end

  assign motor_enable = motor_q;
  assign large_drive_select = large_q;

  ////////////////////////////////////////////////////////////////////////////
  // Memory wait state generator

  assign mem_active = !mreq_n && (!rd_n || !wr_n);

  // Next state for one inserted wait per memory cycle
  always_comb
  begin
    wst_d = wst_q;
    case (wst_q)
      IOD_IDLE: if (mem_active) wst_d = IOD_WAIT;
      IOD_WAIT: wst_d = IOD_DONE;
      IOD_DONE: if (!mem_active) wst_d = IOD_IDLE;
      default: wst_d = IOD_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wst_q <= IOD_IDLE;
    else
      wst_q <= wst_d;
  end

  // Wait asserted for the first cycle of every memory access
  assign wait_n = !((wst_q == IOD_IDLE) && mem_active);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_sel_io_only: assert property (@(posedge clk) disable iff (!rst_n)
    (|sel) |-> (!iorq_n && m1_n))
    else $error("select outside an I/O cycle");

  a_sel_onehot: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0(sel))
    else $error("more than one select");

  a_disp_range: assert property (@(posedge clk) disable iff (!rst_n)
    io_cycle && (addr <= 8'h03) |-> display_select)
    else $error("display select missing");

  a_flop_range: assert property (@(posedge clk) disable iff (!rst_n)
    floppy_select |-> (addr >= 8'h04) && (addr <= 8'h07))
    else $error("floppy select out of range");

  a_ser_range: assert property (@(posedge clk) disable iff (!rst_n)
    serial_controller_select == (io_cycle && addr >= 8'h08 && addr <= 8'h0B))
    else $error("serial select wrong");

  a_tmr_range: assert property (@(posedge clk) disable iff (!rst_n)
    timer_controller_select == (io_cycle && addr >= 8'h0C && addr <= 8'h0F))
    else $error("timer select wrong");

  a_par_range: assert property (@(posedge clk) disable iff (!rst_n)
    parallel_port_select == (io_cycle && addr >= 8'h10 && addr <= 8'h13))
    else $error("parallel select wrong");

  a_dma_range: assert property (@(posedge clk) disable iff (!rst_n)
    dma_select == (io_cycle && addr >= 8'hF0))
    else $error("dma select wrong");

  a_sw_read: assert property (@(posedge clk) disable iff (!rst_n)
    !data_oe_n |-> (data_out == $past(switch_pins, 3)))
    else $error("switch read data wrong");

  a_drive_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (sel[SEL_SW] && !wr_n && wr_n_q) |=> (motor_enable == $past(data_in[MOTOR_BIT]))
      && (large_drive_select == $past(data_in[LARGE_BIT])))
    else $error("drive control not latched");

  a_mem_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (mem_active && wst_q == IOD_IDLE) |-> !wait_n ##1 (wait_n || !mem_active))
    else $error("memory wait not exactly one");

  c_dma_hit: cover property (@(posedge clk) disable iff (!rst_n) dma_select);
  c_sw_write: cover property (@(posedge clk) disable iff (!rst_n)
    sel[SEL_SW] && !wr_n && wr_n_q);
  c_mem_wait: cover property (@(posedge clk) disable iff (!rst_n) !wait_n ##1 wait_n);

endmodule // iod_decoder

/* testbench/iod_cpu_model.sv */
// Processor model issuing I/O, memory and acknowledge cycles
module iod_cpu_model
(
  input wire logic clk,
  output logic [7:0] addr,
  output logic iorq_n,
  output logic mreq_n,
  output logic m1_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idle at time zero
  initial
  begin
    {iorq_n, mreq_n, m1_n, rd_n, wr_n} = 5'h1F;
    addr = 8'h00;
    data_in = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start a cycle after a rising edge; s is {iorq_n, mreq_n, m1_n, rd_n, wr_n}
  task automatic start(input logic [4:0] s, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {iorq_n, mreq_n, m1_n, rd_n, wr_n} <= s;
    addr <= a;
    data_in <= s[0] ? ~data_in : d; // Released data bus shows no stale value
  endtask

  // Drop every strobe, keep the address
  task automatic idle();
    start(5'h1F, addr, 8'h00);
  endtask
endmodule // iod_cpu_model

/* testbench/tb_io_port_address_decoder.sv */
// Self-checking bench for the I/O port decoder
module tb_io_port_address_decoder
  import iod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] switch_pins = 8'hA5;
  logic [7:0] addr, data_in, data_out;
  logic iorq_n, mreq_n, m1_n, rd_n, wr_n, data_oe_n, motor_enable, large_drive_select, wait_n;
  logic [5:0] sel;
  logic [3:0] reg_index;
  logic [7:0] wa [5] = '{8'h15, 8'h17, 8'h18, 8'h14, 8'hF0};
  logic [7:0] wd [5] = '{8'h03, 8'hFE, 8'h03, 8'h01, 8'h02};
  logic [1:0] we [5] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1};
  logic [4:0] mode [3] = '{5'h0D, 5'h0B, 5'h15};
  int n_mismatch = 0;
  int n_compared = 0;

  // Clock generator
  always #20 clk = ~clk;

  iod_cpu_model cpu (.clk(clk), .addr(addr), .iorq_n(iorq_n), .mreq_n(mreq_n),
    .m1_n(m1_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));

  iod_decoder dut (.clk(clk), .rst_n(rst_n), .addr(addr), .iorq_n(iorq_n),
    .mreq_n(mreq_n), .m1_n(m1_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
    .switch_pins(switch_pins), .data_out(data_out), .data_oe_n(data_oe_n),
    .display_select(sel[0]), .floppy_select(sel[1]), .serial_controller_select(sel[2]),
    .timer_controller_select(sel[3]), .parallel_port_select(sel[4]), .dma_select(sel[5]),
    .reg_index(reg_index), .motor_enable(motor_enable),
    .large_drive_select(large_drive_select), .wait_n(wait_n));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Expected one-hot select, order dma par tmr ser flop disp
  function automatic logic [5:0] exp_sel(input logic [7:0] a);
    exp_sel = 6'h00;
    if (a < 8'h14)
      exp_sel[a[4:2]] = 1'b1;
    if (a >= 8'hF0)
      exp_sel[5] = 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    #2000000;
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("drive latches", {6'h00, large_drive_select, motor_enable}, 8'h00);
    // Full address sweep for I/O read, acknowledge and memory cycles
    for (int m = 0; m < 3; m++)
      for (int a = 0; a < 256; a++)
      begin
        cpu.start(mode[m], 8'(a), 8'h00);
        @(negedge clk);
        check("select", {2'h0, sel},
          m == 0 ? {2'h0, exp_sel(8'(a))} : 8'h00);
        check("reg_index", {4'h0, reg_index}, 8'(a) & 8'h0F);
        check("data_oe_n", {7'h00, data_oe_n}, {7'h00, !(m == 0 && a >= 20 && a < 24)});
      end
    cpu.idle();
    // Switch reads with two patterns
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      switch_pins <= i ? 8'h5A : 8'hC3;
      cpu.start(5'h0D, 8'h14 + 8'(i) * 8'h03, 8'h00);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check("switch data", data_out, i ? 8'h5A : 8'hC3);
      cpu.idle();
    end
    // Drive control writes, mapped and unmapped
    foreach (wa[i])
    begin
      cpu.start(5'h0E, wa[i], wd[i]);
      cpu.idle();
      @(negedge clk);
      check("drive latches", {6'h00, large_drive_select, motor_enable}, {6'h00, we[i]});
    end
    // Memory read and write stretch, then an I/O read
    for (int i = 0; i < 3; i++)
    begin
      repeat (2) cpu.idle();
      cpu.start(i == 0 ? 5'h15 : (i == 1 ? 5'h16 : 5'h0D), 8'h40, 8'h11);
      @(negedge clk);
      check("wait_n first", {7'h00, wait_n}, {7'h00, i == 2});
      @(negedge clk);
      check("wait_n second", {7'h00, wait_n}, 8'h01);
    end
    cpu.idle();
    stop_test();
  end
endmodule // tb_io_port_address_decoder
